// *** verilog/c2p_core.sv ***
// Iterative Cartesian to polar converter: I/Q in, magnitude and phase out
//
// Contract
// - Legacy routing takes 18-bit in-phase and quadrature operands per sample.
// - Phase is 18 bits truncated; top 16 to formatter, all 18 to discriminator.
// - 16-bit phase reads as signed -0.5..0.5 or unsigned 0..1 turn.
// - Phase gain is one over two pi, 16-bit resolution.
// - Phase bit 15 weighs 180 degrees; magnitude bit 13 weighs one.
// - Magnitude is 16-bit unsigned, 0 to 2.32, MSB always zero.
// - Magnitude carries the inherent 1.64676 converter gain.
// - Iterate 17 clocks, then latch magnitude and phase into holding register.
// - A new sample before completion latches the partial result instead.
// - Accuracy improves about one bit per added iteration clock.
// - Optional routing feeds full 26-bit FIR output straight to the converter.
// - Direct routing still sends the top 18 phase bits to the discriminator.
// - Resampler bypassed: sampling gated by the AGC data-ready strobe.
// - Resampler enabled: sampling gated by the resampler data-ready strobe.
// - Source select bit: one picks direct FIR, zero picks resampler/AGC path.
// - Quadrature zero bit forces Q input to zero; clear passes both.
`timescale 1ns/100ps

module c2p_core
	import c2p_pkg::*;
#(
	parameter int ITERS = ITER_N                // Iterations to full precision
)
(
	// Clock and reset
	input  wire logic     mclk,
	input  wire logic     arst_n,
	// Configuration levels
	input  wire c2p_cfg_t cfg,
	// Upstream samples and their strobes
	input  wire c2p_leg_t leg_data,
	input  wire c2p_fir_t fir_data,
	input  wire logic     agc_rdy,
	input  wire logic     rsmp_rdy,
	// Results to formatter and discriminator
	output c2p_res_t      res,
	output logic          res_valid
);

	// =====================================================================
	// Types and state
	typedef enum logic [1:0] {
		C2P_IDLE = 2'b01,
		C2P_RUN  = 2'b10
	} c2p_state_t;

	c2p_state_t              state;
	c2p_state_t              next_state;
	logic signed [INT_W-1:0] x;
	logic signed [INT_W-1:0] y;
	logic        [PH_W-1:0]  z;
	logic        [CNT_W-1:0] iter;
	logic signed [INT_W-1:0] next_x;
	logic signed [INT_W-1:0] next_y;
	logic        [PH_W-1:0]  next_z;
	logic        [CNT_W-1:0] next_iter;
	c2p_res_t                next_res;
	logic                    next_res_valid;
	logic        [CNT_W-1:0] rom_addr;
	logic        [PH_W-1:0]  atan_val;

	// =====================================================================
	// Helpers
	// Widen an 18-bit operand so both routings share one full-scale
	function automatic logic signed [INT_W-1:0] c2p_from_leg(input logic [LEG_W-1:0] v);
		c2p_from_leg = INT_W'($signed({v, {LEG_SHIFT{1'b0}}}));
	endfunction

	function automatic logic signed [INT_W-1:0] c2p_from_fir(input logic [FIR_W-1:0] v);
		c2p_from_fir = INT_W'($signed(v));
	endfunction

	// Pack datapath into output fields; plain truncation, no rounding
	function automatic c2p_res_t c2p_pack(input logic signed [INT_W-1:0] mx,
	                                      input logic [PH_W-1:0] pz);
		c2p_pack.mag        = mx[MAG_LSB+OUT_W-1:MAG_LSB];
		c2p_pack.phase      = pz[PH_W-1:PH_W-OUT_W];
		c2p_pack.phase_disc = pz[PH_W-1:PH_W-PHD_W];
	endfunction

	// =====================================================================
	// Sample gating and operand selection
	logic                    smp_stb;
	logic signed [INT_W-1:0] in_i;
	logic signed [INT_W-1:0] in_q;

	// Strobe follows whichever stage last touched the data
	assign smp_stb = cfg.rsmp_en ? rsmp_rdy : agc_rdy;

	// Direct FIR path avoids the 18-bit selection and AGC quantisation
	always_comb
	begin
		if (cfg.src_fir)
		begin
			in_i = c2p_from_fir(fir_data.i);
			in_q = c2p_from_fir(fir_data.q);
		end
		else
		begin
			in_i = c2p_from_leg(leg_data.i);
			in_q = c2p_from_leg(leg_data.q);
		end
		if (cfg.q_zero)
			in_q = '0;
	end

	// =====================================================================
	// Angle table; index is presented one clock ahead of its use
	// A load mid-run must restart at step zero, or the first step uses a stale angle
	assign rom_addr = ((state == C2P_RUN) && !smp_stb) ? CNT_W'(iter + CNT_ONE) : CNT_ZERO;

	c2p_atan_rom #(
		.DEPTH (ITERS),
		.AW    (CNT_W),
		.DW    (PH_W)
	) u_atan (
		.mclk   (mclk),
		.arst_n (arst_n),
		.addr   (rom_addr),
		.data   (atan_val)
	);

	// =====================================================================
	// Iteration, early latch and load
	logic signed [INT_W-1:0] step_x;
	logic signed [INT_W-1:0] step_y;
	logic        [PH_W-1:0]  step_z;
	logic                    last_iter;

	always_comb
	begin
		next_state     = state;
		next_x         = x;
		next_y         = y;
		next_z         = z;
		next_iter      = iter;
		next_res       = res;
		next_res_valid = 1'b0;
		last_iter      = (state == C2P_RUN) && (iter == CNT_W'(ITERS - 1));

		// Vectoring step drives y to zero; x grows by the 1.64676 gain
		if (y[INT_W-1])
		begin
			step_x = x - (y >>> iter);
			step_y = y + (x >>> iter);
			step_z = z - atan_val;
		end
		else
		begin
			step_x = x + (y >>> iter);
			step_y = y - (x >>> iter);
			step_z = z + atan_val;
		end

		case (state)
			C2P_IDLE:
			begin
				next_state = C2P_IDLE;
			end
			C2P_RUN:
			begin
				// Each clock buys roughly one more bit of phase
				next_x    = step_x;
				next_y    = step_y;
				next_z    = step_z;
				next_iter = CNT_W'(iter + CNT_ONE);
				if (last_iter)
				begin
					next_res       = c2p_pack(step_x, step_z);
					next_res_valid = 1'b1;
					next_state     = C2P_IDLE;
				end
				else if (smp_stb)
				begin
					// Cut short: trade resolution for throughput
					next_res       = c2p_pack(x, z);
					next_res_valid = 1'b1;
				end
			end
			default:
			begin
				next_state = C2P_IDLE;
			end
		endcase

		// Load, with a half-turn pre-rotation when I is negative, so iterations cover +-90 degrees
		if (smp_stb)
		begin
			next_state = C2P_RUN;
			next_iter  = CNT_ZERO;
			if (in_i[INT_W-1])
			begin
				next_x = -in_i;
				next_y = -in_q;
				next_z = PH_HALF;
			end
			else
			begin
				next_x = in_i;
				next_y = in_q;
				next_z = PH_ZERO;
			end
		end
	end

	// Registers only
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state     <= C2P_IDLE;
			x         <= '0;
			y         <= '0;
			z         <= '0;
			iter      <= CNT_ZERO;
			res       <= '0;
			res_valid <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			x         <= next_x;
			y         <= next_y;
			z         <= next_z;
			iter      <= next_iter;
			res       <= next_res;
			res_valid <= next_res_valid;
		end
	end

endmodule // c2p_core

// *** common/c2p_pkg.sv ***
// Shared constants and carrier types for the Cartesian to polar converter
package c2p_pkg;

	// =====================================================================
	// Widths
	localparam int LEG_W   = 18;                // Legacy resampler/AGC operand width
	localparam int FIR_W   = 26;                // Direct FIR operand width
	localparam int INT_W   = 28;                // Datapath width, two guard bits for growth
	localparam int PH_W    = 20;                // Phase accumulator, truncated on output
	localparam int PHD_W   = 18;                // Phase width to the discriminator
	localparam int OUT_W   = 16;                // Magnitude and phase width to the formatter
	localparam int ITER_N  = 17;                // Iterations for full precision
	localparam int CNT_W   = 5;                 // Iteration counter width

	// =====================================================================
	// Field positions and fixed values
	localparam int LEG_SHIFT = FIR_W - LEG_W;   // Aligns 18-bit full scale to 26-bit full scale
	localparam int MAG_LSB   = 12;              // Datapath bit that lands on magnitude bit 0
	localparam int CFG_SRC_BIT   = 13;          // Control word 27: source select bit
	localparam int CFG_QZERO_BIT = 14;          // Control word 27: quadrature zero bit
	localparam logic [PH_W-1:0] PH_HALF = 20'h80000;  // Half turn, 180 degrees
	localparam logic [PH_W-1:0] PH_ZERO = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

	// =====================================================================
	// Carriers
	typedef struct packed {
		logic [LEG_W-1:0] i;
		logic [LEG_W-1:0] q;
	} c2p_leg_t;

	typedef struct packed {
		logic [FIR_W-1:0] i;
		logic [FIR_W-1:0] q;
	} c2p_fir_t;

	typedef struct packed {
		logic             src_fir;              // Control word 27 bit 13
		logic             q_zero;               // Control word 27 bit 14
		logic             rsmp_en;              // Resampler path active
	} c2p_cfg_t;

	typedef struct packed {
		logic [OUT_W-1:0] mag;
		logic [OUT_W-1:0] phase;
		logic [PHD_W-1:0] phase_disc;
	} c2p_res_t;

endpackage

// *** verilog/c2p_atan_rom.sv ***
// Arctangent table for the iterative converter, registered read
`timescale 1ns/100ps

module c2p_atan_rom
	import c2p_pkg::*;
#(
	parameter int DEPTH = ITER_N,
	parameter int AW    = CNT_W,
	parameter int DW    = PH_W
)
(
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          arst_n,
	// Read port
	input  wire logic [AW-1:0] addr,
	output logic      [DW-1:0] data
);

	// =====================================================================
	// Table: atan(2^-k) in turns, scaled by 2^20, rounded
	function automatic logic [DW-1:0] c2p_atan(input logic [AW-1:0] k);
		case (k)
			5'h00:   c2p_atan = 20'h20000;
			5'h01:   c2p_atan = 20'h12e40;
			5'h02:   c2p_atan = 20'h09fb3;
			5'h03:   c2p_atan = 20'h05111;
			5'h04:   c2p_atan = 20'h028b1;
			5'h05:   c2p_atan = 20'h0145d;
			5'h06:   c2p_atan = 20'h00a2f;
			5'h07:   c2p_atan = 20'h00518;
			5'h08:   c2p_atan = 20'h0028c;
			5'h09:   c2p_atan = 20'h00146;
			5'h0a:   c2p_atan = 20'h000a3;
			5'h0b:   c2p_atan = 20'h00051;
			5'h0c:   c2p_atan = 20'h00029;
			5'h0d:   c2p_atan = 20'h00014;
			5'h0e:   c2p_atan = 20'h0000a;
			5'h0f:   c2p_atan = 20'h00005;
			5'h10:   c2p_atan = 20'h00003;
			default: c2p_atan = 20'h00000;  // Past the last step the angle is negligible
		endcase
	endfunction

	// Read data come out of a register, so the core presents the next index early
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			data <= '0;
		else
			data <= c2p_atan(addr);
	end

endmodule // c2p_atan_rom

// *** sim/c2p_src.sv ***
// Upstream filter path model: I/Q samples and data ready strobes
`timescale 1ns/100ps
module c2p_src
	import c2p_pkg::*;
(
	// Clock
	input  wire logic mclk,
	// Samples and strobes
	output c2p_leg_t  leg_data,
	output c2p_fir_t  fir_data,
	output logic      agc_rdy,
	output logic      rsmp_rdy
);
	// ====================
	// Quiet at time zero
	initial
	begin
		leg_data = '0;
		fir_data = '0;
		agc_rdy = 1'b0;
		rsmp_rdy = 1'b0;
	end
	// One sample per call; lines flip after the strobe so a late capture shows up
	// The unselected route carries the inverse, so a wrong route pick is visible
	task automatic send(input logic [FIR_W-1:0] i, input logic [FIR_W-1:0] q, input logic rs,
		input logic fir);
		@(posedge mclk);
		fir_data <= fir ? {i, q} : ~{i, q};
		leg_data <= fir ? ~{i[FIR_W-1 -: LEG_W], q[FIR_W-1 -: LEG_W]}
			: {i[FIR_W-1 -: LEG_W], q[FIR_W-1 -: LEG_W]};
		agc_rdy <= !rs;
		rsmp_rdy <= rs;
		@(posedge mclk);
		fir_data <= ~{i, q};
		leg_data <= ~{i[FIR_W-1 -: LEG_W], q[FIR_W-1 -: LEG_W]};
		agc_rdy <= 1'b0;
		rsmp_rdy <= 1'b0;
	endtask
endmodule // c2p_src

// *** sim/c2p_chk.sv ***
// Port assertions for the Cartesian to polar converter
`timescale 1ns/100ps
module c2p_chk
	import c2p_pkg::*;
#(
	parameter int ITERS = ITER_N
)
(
	// Clock and reset
	input  wire logic     mclk,
	input  wire logic     arst_n,
	// Configuration and upstream
	input  wire c2p_cfg_t cfg,
	input  wire c2p_leg_t leg_data,
	input  wire c2p_fir_t fir_data,
	input  wire logic     agc_rdy,
	input  wire logic     rsmp_rdy,
	// Results
	input  wire c2p_res_t res,
	input  wire logic     res_valid
);
	// ====================
	// Sample tracking
	logic             stb;
	logic             busy, next_busy;
	logic             due, next_due;
	logic [CNT_W-1:0] since, next_since;
	// Strobe picked as the converter picks it
	assign stb = cfg.rsmp_en ? rsmp_rdy : agc_rdy;
	// Counter runs on while idle; busy gates every use
	always_comb
	begin
		next_since = stb ? CNT_ONE : since + CNT_ONE;
		next_busy = stb || (busy && since != CNT_W'(ITERS));
		next_due = busy && (stb || since == CNT_W'(ITERS));
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			{since, busy, due} <= '0;
		else
			{since, busy, due} <= {next_since, next_busy, next_due};
	end
	// ====================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	AST_HOLD: assert property (!res_valid |-> $stable(res))
		else $error("result moved without valid");
	AST_MSB: assert property (res.mag[15] == 1'b0)
		else $error("magnitude top bit set");
	AST_RANGE: assert property (res.mag <= 16'h4a3d)
		else $error("magnitude out of range");
	AST_DISC: assert property (res.phase == res.phase_disc[PHD_W-1 -: OUT_W])
		else $error("phase words disagree");
	AST_FULL: assert property (busy && since == CNT_W'(ITERS) |=> res_valid)
		else $error("no result after full run");
	AST_EARLY: assert property (stb && busy && since < CNT_W'(ITERS) |=> res_valid)
		else $error("no partial result on new sample");
	AST_CAUSE: assert property (res_valid |-> due)
		else $error("valid without cause");
	AST_IDLE: assert property (!busy && !stb |=> !res_valid)
		else $error("valid while idle");
endmodule // c2p_chk

// *** sim/tb_top.sv ***
// Self-checking bench for the Cartesian to polar converter
`timescale 1ns/100ps
module tb_top
	import c2p_pkg::*;
;
	logic     mclk;
	logic     arst_n;
	c2p_cfg_t cfg;
	c2p_leg_t leg_data;
	c2p_fir_t fir_data;
	logic     agc_rdy;
	logic     rsmp_rdy;
	c2p_res_t res;
	logic     res_valid;
	int       bad_count;
	int       total_checks;
	int       cycles;
	int       seed;
	int       gaps[2] = '{5, 0};
	real      x, y, x2, y2;
	// ====================
	// Design and upstream model
	c2p_core #(.ITERS(ITER_N)) c2p_core_i (.mclk, .arst_n, .cfg, .leg_data, .fir_data,
		.agc_rdy, .rsmp_rdy, .res, .res_valid);
	c2p_src c2p_src_i (.mclk, .leg_data, .fir_data, .agc_rdy, .rsmp_rdy);
	// 100 ns clock and a hang guard well above the run length
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	// Distance compare, optionally modulo a full turn
	task automatic check(input logic [17:0] seen, input int exp, input int tol, input int md);
		int d;
		d = int'(seen) - exp;
		if (md > 0)
			d = ((d % md) + md + md / 2) % md - md / 2;
		total_checks++;
		if ($isunknown(seen) || d > tol || d < -tol)
		begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Random sample kept inside unit circle, legacy keeps only 18 top bits
	task automatic fire(input logic bad, output real xo, output real yo);
		logic [FIR_W-1:0] i;
		logic [FIR_W-1:0] q;
		i = FIR_W'($random(seed) >>> 1);
		q = FIR_W'($random(seed) >>> 1);
		i = {i[FIR_W-1], i[FIR_W-1:1]};
		q = {q[FIR_W-1], q[FIR_W-1:1]};
		if (!cfg.src_fir)
			{i[LEG_SHIFT-1:0], q[LEG_SHIFT-1:0]} = '0;
		xo = $itor($signed(i)) / 33554432.0;
		yo = cfg.q_zero ? 0.0 : $itor($signed(q)) / 33554432.0;
		c2p_src_i.send(i, q, cfg.rsmp_en ^ bad, cfg.src_fir);
	endtask
	// Counts edges to valid, then, when tol is above zero, compares against the ideal vector
	task automatic collect(input int n_exp, input real xe, input real ye, input int tol);
		int n;
		real a;
		real r;
		n = 0;
		#1;
		while (res_valid !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(18'(n), n_exp, 0, 0);
		// Ideal phase in 16-bit turns, ideal magnitude with bit 13 as one
		a = 65536.0 * $atan2(ye, xe) / 6.2831853;
		r = 1.64676 * 8192.0 * $sqrt(xe * xe + ye * ye);
		if (tol > 0)
		begin
			check(18'(res.mag), int'($floor(r)), tol + 4, 0);
			check(18'(res.phase), int'($floor(a)), tol, 65536);
			check(res.phase_disc, int'($floor(4.0 * a)), 4 * tol, 262144);
		end
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Every routing choice, a foreign strobe, then early aborts
	initial
	begin
		arst_n = 1'b0;
		cfg = '0;
		seed = 32'h12e7eb41;
		bad_count = 0;
		total_checks = 0;
		cycles = 0;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		for (int m = 0; m < 16; m++)
		begin
			@(posedge mclk);
			// Resampler stays bypassed whenever the direct FIR route is picked
			cfg <= c2p_cfg_t'({m[2:1], m[0] & !m[2]});
			@(posedge mclk);
			fire(1'b0, x, y);
			collect(ITER_N, x, y, 4);
		end
		fire(1'b1, x, y);
		repeat (20)
		begin
			@(posedge mclk);
			#1;
			check(18'(res_valid), 0, 0, 0);
		end
		@(posedge mclk);
		cfg <= c2p_cfg_t'(3'b100);
		@(posedge mclk);
		foreach (gaps[g])
		begin
			fire(1'b0, x, y);
			repeat (gaps[g]) @(posedge mclk);
			fire(1'b0, x2, y2);
			// Six steps must land within about 3.5 degrees of phase
			collect(0, x, y, (gaps[g] > 0) ? 637 : 0);
			@(posedge mclk);
			collect(ITER_N - 1, x2, y2, 4);
		end
		end_of_test();
	end
endmodule // tb_top
// Port checker on the converter
bind c2p_core c2p_chk #(.ITERS(ITERS)) c2p_chk_i (.mclk, .arst_n, .cfg, .leg_data, .fir_data,
	.agc_rdy, .rsmp_rdy, .res, .res_valid);
